// [hw/ptws_top.sv]
/*
  Period timer with prescaler, period match and postscaler, with a
  classic Wishbone register slave and a masked level interrupt.
  Assumes one clock at 50 MHz taken as the oscillator, synchronous
  active-high reset, and a bus master that keeps classic single cycles.
*/
// Register access over Wishbone is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module ptws_top
  import ptws_pkg::*;
(
  // Clock, reset and clock enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Interrupt and time base
  output logic             irq_o,
  output logic             pwm_timebase_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [1:0]  inst_q;      // Oscillator to instruction-rate divider
  logic [1:0]  inst_d;
  logic [7:0]  count_q;     // timer_count
  logic [7:0]  count_d;
  logic [7:0]  period_q;    // period_match_value
  logic [7:0]  period_d;
  logic [7:0]  ctrl_q;      // timer_control_reg
  logic [7:0]  ctrl_d;
  logic [7:0]  flag_q;      // peripheral_flag_reg, sticky
  logic [7:0]  flag_d;
  logic [7:0]  mask_q;      // Interrupt mask, same layout as flags
  logic [7:0]  mask_d;
  logic        ack_q;       // Bus acknowledge
  logic        ack_d;
  logic [31:0] rdat_q;      // Registered read data
  logic [31:0] rdat_d;
  logic        irq_q;       // Level interrupt
  logic        irq_d;
  logic        tb_q;        // Registered match for the PWM unit
  logic        tb_d;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        req;         // New request this cycle
  logic        wr_lo;       // Write with the low byte lane enabled
  logic [5:0]  idx;         // Word index of the access
  logic [7:0]  wbyte;       // Write data low byte
  logic        wr_count;    // Software write to the count
  logic        wr_ctrl;     // Software write to the control
  logic        wr_period;   // Software write to the period
  logic        wr_flag;     // Write-one-to-clear of flags
  logic        wr_mask;     // Write to the mask

  // Only the low byte lane carries data; upper lanes are ignored
  assign req       = ce_i && wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_lo     = req && wb_we_i && wb_sel_i[0];
  assign idx       = wb_adr_i[7:2];
  assign wbyte     = wb_dat_i[7:0];
  assign wr_count  = wr_lo && (idx == IDX_COUNT);
  assign wr_ctrl   = wr_lo && (idx == IDX_CTRL);
  assign wr_period = wr_lo && (idx == IDX_PERIOD);
  assign wr_flag   = wr_lo && (idx == IDX_FLAG);
  assign wr_mask   = wr_lo && (idx == IDX_MASK);

  // Read mux; unmapped words read as zero
  function automatic logic [7:0] rd_byte(input logic [5:0] i);
    logic [7:0] r;
    r = 8'h00;
    unique case (i)
      IDX_COUNT:  r = count_q;
      IDX_PERIOD: r = period_q;
      IDX_CTRL:   r = ctrl_q & CTRL_MASK;
      IDX_FLAG:   r = flag_q & FLAG_MASK;
      IDX_MASK:   r = mask_q & FLAG_MASK;
      default:    r = 8'h00;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Scalers
  // ----------------------------------------------------------------
  ptws_scale_if sif ();

  logic match;              // Period match this cycle

  // Instruction tick runs free of the run bit; the run bit and ce_i low both stop the timer
  assign sif.inst_tick = ce_i && (inst_q == INST_DIV_LAST);
  assign sif.run       = ctrl_q[CTRL_RUN_BIT];
  assign sif.presc_sel = ctrl_q[CTRL_PRESC_LSB +: 2];
  assign sif.post_sel  = ctrl_q[CTRL_POST_LSB +: 4];
  // Writing count or control restarts both scalers from zero
  assign sif.clr       = wr_count || wr_ctrl;
  // A software count write in the same cycle outranks the match
  assign match         = sif.cnt_tick && (count_q == period_q) && !wr_count;
  assign sif.match     = match;

  ptws_prescaler u_presc (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sif   (sif)
  );

  ptws_postscaler u_post (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sif   (sif)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Timer, registers, bus answer and interrupt in one pass
  always_comb begin
    inst_d   = inst_q + 2'h1;
    count_d  = count_q;
    period_d = period_q;
    ctrl_d   = ctrl_q;
    mask_d   = mask_q;
    // Software write wins over counting
    if (wr_count) begin
      count_d = wbyte;
    end else if (sif.cnt_tick) begin
      if (count_q == period_q) begin
        count_d = 8'h00;
      end else begin
        count_d = count_q + 8'h01;
      end
    end
    if (wr_period) begin
      period_d = wbyte;
    end
    if (wr_ctrl) begin
      ctrl_d = wbyte & CTRL_MASK;
    end
    if (wr_mask) begin
      mask_d = wbyte & FLAG_MASK;
    end
    // Set beats a clear landing in the same cycle
    flag_d = flag_q;
    if (wr_flag) begin
      flag_d = flag_q & ~wbyte;
    end
    if (sif.post_evt) begin
      flag_d[FLAG_MATCH_BIT] = 1'b1;
    end
    // Answer one cycle after the request, drop the cycle after
    ack_d  = req;
    rdat_d = {24'h000000, rd_byte(idx)};
    irq_d  = |(flag_q & mask_q & FLAG_MASK);
    tb_d   = match;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Clock enable low freezes everything, the bus answer included
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inst_q   <= 2'h0;
      count_q  <= COUNT_RST;
      period_q <= PERIOD_RST;
      ctrl_q   <= CTRL_RST;
      flag_q   <= 8'h00;
      mask_q   <= 8'h00;
      ack_q    <= 1'b0;
      rdat_q   <= 32'h00000000;
      irq_q    <= 1'b0;
      tb_q     <= 1'b0;
    end else if (ce_i) begin
      inst_q   <= inst_d;
      count_q  <= count_d;
      period_q <= period_d;
      ctrl_q   <= ctrl_d;
      flag_q   <= flag_d;
      mask_q   <= mask_d;
      ack_q    <= ack_d;
      rdat_q   <= rdat_d;
      irq_q    <= irq_d;
      tb_q     <= tb_d;
    end
  end

  // Outputs come straight from flip-flops
  assign wb_ack_o       = ack_q;
  assign wb_dat_o       = rdat_q;
  assign irq_o          = irq_q;
  assign pwm_timebase_o = tb_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_reset_vals;
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> (count_q == 8'h00) && (period_q == 8'hff);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad values after reset");

  property p_wrap;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && match) |=> (count_q == 8'h00);
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not return to zero");

  property p_inc;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && sif.cnt_tick && !wr_count && (count_q != period_q))
      |=> (count_q == $past(count_q) + 8'h01);
  endproperty
  a_inc: assert property (p_inc) else $error("count did not advance by one");

  property p_stopped;
    @(posedge clk_i) disable iff (rst_i)
    (!ctrl_q[CTRL_RUN_BIT] && !wr_count && !wr_ctrl) |=> $stable(count_q);
  endproperty
  a_stopped: assert property (p_stopped) else $error("count moved while stopped");

  property p_flag_set;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && sif.post_evt) |=> flag_q[FLAG_MATCH_BIT];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("match flag not set");

  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && |(flag_q & mask_q & FLAG_MASK)) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_timebase;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && match) |=> pwm_timebase_o ##1 (!pwm_timebase_o || $past(match) || !$past(ce_i));
  endproperty
  a_timebase: assert property (p_timebase) else $error("time base pulse wrong");

  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o ##1 (!wb_ack_o || !$past(ce_i));
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer not one cycle");

  // Instruction ticks seen since the last count tick, kept apart from
  // the prescaler so that a wrong divider cannot check itself
  logic [3:0] gap_q;        // Ticks seen in this prescale period
  logic [3:0] gap_d;
  logic [3:0] gap_want;     // Last tick count for the selected ratio

  // Next gap value; a select change always comes with a clear
  always_comb begin
    gap_want = PRESC_LAST_1;
    if (ctrl_q[CTRL_PRESC_LSB + 1]) begin
      gap_want = PRESC_LAST_16;
    end else if (ctrl_q[CTRL_PRESC_LSB]) begin
      gap_want = PRESC_LAST_4;
    end
    gap_d = gap_q;
    if (sif.clr || sif.cnt_tick) begin
      gap_d = 4'h0;
    end else if (sif.inst_tick && sif.run) begin
      gap_d = gap_q + 4'h1;
    end
  end

  // Gap register, cleared by reset like the prescaler
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_q <= 4'h0;
    end else begin
      gap_q <= gap_d;
    end
  end

  property p_presc_gap;
    @(posedge clk_i) disable iff (rst_i)
    sif.cnt_tick |-> (gap_q == gap_want);
  endproperty
  a_presc_gap: assert property (p_presc_gap) else $error("prescale gap wrong");

  c_wrap:  cover property (@(posedge clk_i) disable iff (rst_i) ce_i && match);
  c_flag:  cover property (@(posedge clk_i) disable iff (rst_i) ce_i && sif.post_evt);
  c_irq:   cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
  c_p16:   cover property (@(posedge clk_i) disable iff (rst_i)
                           sif.cnt_tick && ctrl_q[CTRL_PRESC_LSB + 1]);

endmodule

`default_nettype wire

// [hw/ptws_pkg.sv]
/*
  Constants shared by the period timer with scalers: register indices,
  field positions, reset values and the clock division figures.
  Assumes nothing of its surroundings; imported whole by every module.
*/
package ptws_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_FLAG   = 6'h0c;  // Sticky event flags
  localparam logic [5:0] IDX_MASK   = 6'h0d;  // Interrupt mask
  localparam logic [5:0] IDX_COUNT  = 6'h11;  // Timer count
  localparam logic [5:0] IDX_CTRL   = 6'h12;  // Timer control
  localparam logic [5:0] IDX_PERIOD = 6'h13;  // Period match value

  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam int         CTRL_PRESC_LSB = 0;      // Prescale select, 2 bits
  localparam int         CTRL_RUN_BIT   = 2;      // Run enable
  localparam int         CTRL_POST_LSB  = 3;      // Postscale select, 4 bits
  localparam logic [7:0] CTRL_MASK      = 8'h7f;  // Bit 7 reads as zero
  localparam int         FLAG_MATCH_BIT = 1;      // Period match flag
  localparam logic [7:0] FLAG_MASK      = 8'h02;  // Implemented flag bits

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] COUNT_RST     = 8'h00;
  localparam logic [7:0] PERIOD_RST    = 8'hff;
  localparam logic [7:0] CTRL_RST      = 8'h00;
  localparam logic [1:0] INST_DIV_LAST = 2'h3;    // Oscillator divided by four
  localparam logic [3:0] PRESC_LAST_1  = 4'h0;    // 1:1
  localparam logic [3:0] PRESC_LAST_4  = 4'h3;    // 1:4
  localparam logic [3:0] PRESC_LAST_16 = 4'hf;    // 1:16

  // Last prescaler count for a select code; upper bit set means 1:16
  function automatic logic [3:0] ptws_presc_last(input logic [1:0] sel);
    logic [3:0] r;
    r = PRESC_LAST_1;
    if (sel[1]) begin
      r = PRESC_LAST_16;
    end else if (sel[0]) begin
      r = PRESC_LAST_4;
    end
    return r;
  endfunction

endpackage

// [hw/ptws_scale_if.sv]
/*
  Carrier between the timer core and its prescaler and postscaler.
  Assumes all signals are sampled on the one system clock.
*/
`timescale 1ns/10ps
`default_nettype none

interface ptws_scale_if;
  logic       inst_tick;  // Instruction-rate tick, already clock-enabled
  logic       run;        // Timer run enable
  logic       clr;        // Clear both scalers
  logic [1:0] presc_sel;  // Prescale select
  logic       cnt_tick;   // Prescaled count tick
  logic       match;      // Period match event
  logic [3:0] post_sel;   // Postscale select
  logic       post_evt;   // Postscaled event

  modport core  (output inst_tick, run, clr, presc_sel, match, post_sel,
                 input  cnt_tick, post_evt);
  modport presc (input  inst_tick, run, clr, presc_sel, output cnt_tick);
  modport post  (input  match, clr, post_sel, output post_evt);
endinterface

`default_nettype wire

// [hw/ptws_prescaler.sv]
/*
  Input prescaler: passes one of 1, 4 or 16 instruction ticks on as a count tick.
  Assumes the core gates inst_tick and clr with the clock enable.
*/
`timescale 1ns/10ps
`default_nettype none

module ptws_prescaler
  import ptws_pkg::*;
(
  // Clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  // Link to the core
  ptws_scale_if.presc sif
);

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  logic [3:0] div_q;  // Ticks seen in this prescale period
  logic [3:0] div_d;
  logic [3:0] last;   // Final count for the chosen ratio

  // Next divider value; frozen while stopped, cleared by the control write that restarts it
  always_comb begin
    last         = ptws_presc_last(sif.presc_sel);
    div_d        = div_q;
    sif.cnt_tick = 1'b0;
    if (sif.clr) begin
      div_d = 4'h0;
    end else if (sif.inst_tick && sif.run) begin
      if (div_q >= last) begin
        div_d        = 4'h0;
        sif.cnt_tick = 1'b1;
      end else begin
        div_d = div_q + 4'h1;
      end
    end
  end

  // Register stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_presc_ratio;
    @(posedge clk_i) disable iff (rst_i)
    sif.cnt_tick |-> sif.run && sif.inst_tick && (div_q >= last);
  endproperty
  a_presc_ratio: assert property (p_presc_ratio) else $error("prescale tick off ratio");

endmodule

`default_nettype wire

// [hw/ptws_postscaler.sv]
/*
  Output postscaler: one event per 1 to 16 period matches.
  Assumes match and clr arrive already gated by the clock enable.
*/
`timescale 1ns/10ps
`default_nettype none

module ptws_postscaler
  import ptws_pkg::*;
(
  // Clock and reset
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  // Link to the core
  ptws_scale_if.post sif
);

  // ----------------------------------------------------------------
  // Match counter
  // ----------------------------------------------------------------
  logic [3:0] cnt_q;  // Matches counted in this group
  logic [3:0] cnt_d;

  // Code n gives a ratio of n+1; a lowered select wraps through 15
  always_comb begin
    cnt_d        = cnt_q;
    sif.post_evt = 1'b0;
    if (sif.clr) begin
      cnt_d = 4'h0;
    end else if (sif.match) begin
      if (cnt_q == sif.post_sel) begin
        cnt_d        = 4'h0;
        sif.post_evt = 1'b1;
      end else begin
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  // Register stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_post_ratio;
    @(posedge clk_i) disable iff (rst_i)
    sif.post_evt |-> sif.match && (cnt_q == sif.post_sel);
  endproperty
  a_post_ratio: assert property (p_post_ratio) else $error("postscale event off ratio");

endmodule

`default_nettype wire

// [bench/tb.sv]
/*
  Self-checking bench for the period timer with scalers: register access,
  prescale rates, period wrap, postscale counts, interrupt and stop.
  Assumes the package, the interface and the design files are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module tb
  import ptws_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic        clk_i    = 1'b0;   // 50 MHz system clock
  logic        rst_i    = 1'b1;   // Held for six cycles at start
  logic        ce_i     = 1'b1;   // Clock enable, dropped once
  logic        wb_cyc_i = 1'b0;   // Bus cycle
  logic        wb_stb_i = 1'b0;   // Bus strobe
  logic        wb_we_i  = 1'b0;   // Bus direction
  logic [7:0]  wb_adr_i = 8'h00;  // Byte address
  logic [3:0]  wb_sel_i = 4'h0;   // Byte lanes
  logic [31:0] wb_dat_i = 32'h0;  // Write data
  logic [31:0] wb_dat_o;          // Read data
  logic        wb_ack_o;          // Acknowledge
  logic        irq_o;             // Level interrupt
  logic        pwm_timebase_o;    // Period match pulse
  int          mismatches = 0;    // Failed comparisons
  int          checked    = 0;    // All comparisons
  logic [31:0] q;                 // Last read word
  int          n;                 // Loop index
  int          a;                 // Cycle count
  int          np;                // Pulse count

  // Half period of 10 ns gives 20 ns
  always begin
    #10 clk_i = ~clk_i;
  end

  ptws_top u_ptws_top (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .ce_i           (ce_i),
    .wb_cyc_i       (wb_cyc_i),
    .wb_stb_i       (wb_stb_i),
    .wb_we_i        (wb_we_i),
    .wb_adr_i       (wb_adr_i),
    .wb_sel_i       (wb_sel_i),
    .wb_dat_i       (wb_dat_i),
    .wb_dat_o       (wb_dat_o),
    .wb_ack_o       (wb_ack_o),
    .irq_o          (irq_o),
    .pwm_timebase_o (pwm_timebase_o)
  );

  // ----------------------------------------------------------------
  // Verdict, comparisons and bus cycles
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Register values and single outputs, four-state compare
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Counts measured by the bench itself
  task automatic chk_cnt(input int got, input int exp, input string what);
    checked++;
    if (got != exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  // One classic cycle; data is taken at the edge where ack is seen
  task automatic xfer(input logic we, input logic [5:0] idx, input logic [7:0] dat,
                      input logic [3:0] sel, output logic [31:0] rdata);
    int w;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= sel;
    wb_dat_i <= {24'h0, dat};
    w = 0;
    do begin
      @(posedge clk_i);
      w++;
    end while (wb_ack_o !== 1'b1 && w < 100);
    rdata = wb_dat_o;
    if (w >= 100) begin
      mismatches++;
      $display("[ERR] %0t bus cycle never acknowledged", $time);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] dat);
    logic [31:0] dummy;
    xfer(1'b1, idx, dat, 4'hf, dummy);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp, input string what);
    logic [31:0] r;
    xfer(1'b0, idx, 8'h00, 4'hf, r);
    chk_reg(r, {24'h0, exp}, what);
  endtask

  // Count edges up to the next time base pulse; a missing pulse is a mismatch after 1000 edges
  task automatic wait_pulse(output int c);
    c = 0;
    do begin
      @(posedge clk_i);
      c++;
    end while (pwm_timebase_o !== 1'b1 && c < 1000);
    if (c >= 1000) begin
      mismatches++;
      $display("[ERR] %0t no time base pulse", $time);
    end
  endtask

  // ----------------------------------------------------------------
  // Watchdog: the tests need well under 10000 cycles
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset state of count, period, control, flag and the interrupt
    rd_chk(IDX_COUNT, 8'h00, "count reset");
    rd_chk(IDX_PERIOD, 8'hff, "period reset");
    rd_chk(IDX_CTRL, 8'h00, "ctrl reset");
    rd_chk(IDX_FLAG, 8'h00, "flag reset");
    chk_reg({31'h0, irq_o}, 32'h0, "irq reset");
    // Read back, ignored lane, unmapped word, unimplemented bit 7
    wr(IDX_COUNT, 8'h5a);
    rd_chk(IDX_COUNT, 8'h5a, "count rw");
    xfer(1'b1, IDX_COUNT, 8'h33, 4'he, q);
    rd_chk(IDX_COUNT, 8'h5a, "lane0 off");
    wr(IDX_PERIOD, 8'h3c);
    rd_chk(IDX_PERIOD, 8'h3c, "period rw");
    wr(6'h3f, 8'ha5);
    rd_chk(6'h3f, 8'h00, "unmapped");
    wr(IDX_CTRL, 8'hfb);
    rd_chk(IDX_CTRL, 8'h7b, "ctrl rw");
    // Run about 25 ticks, then stop: the count must hold
    wr(IDX_CTRL, 8'h00);
    wr(IDX_COUNT, 8'h00);
    wr(IDX_PERIOD, 8'hff);
    wr(IDX_CTRL, 8'h04);
    repeat (100) @(posedge clk_i);
    wr(IDX_CTRL, 8'h00);
    xfer(1'b0, IDX_COUNT, 8'h00, 4'hf, q);
    chk_cnt(int'(q[7:0] >= 8'h14 && q[7:0] <= 8'h20), 1, "run rate");
    repeat (100) @(posedge clk_i);
    rd_chk(IDX_COUNT, q[7:0], "stopped");
    // Period 2: three count ticks per match, 4, 16 or 64 clocks per tick by prescale code
    wr(IDX_PERIOD, 8'h02);
    wr(IDX_COUNT, 8'h00);
    for (n = 0; n < 4; n++) begin
      wr(IDX_CTRL, {6'h01, n[1:0]});
      wait_pulse(a);
      wait_pulse(a);
      chk_cnt(a, 12 * ((n == 0) ? 1 : (n == 1) ? 4 : 16), "match spacing");
    end
    // Clock enable low freezes the timer, no pulse may appear
    wr(IDX_CTRL, 8'h04);
    wait_pulse(a);
    ce_i <= 1'b0;
    np = 0;
    repeat (40) begin
      @(posedge clk_i);
      if (pwm_timebase_o === 1'b1) np++;
    end
    ce_i <= 1'b1;
    chk_cnt(np, 0, "frozen");
    // Every postscale code: matches counted up to the interrupt
    wr(IDX_MASK, 8'h02);
    wr(IDX_PERIOD, 8'h01);
    for (n = 0; n < 16; n++) begin
      wr(IDX_CTRL, 8'h00);
      wr(IDX_COUNT, 8'h00);
      wr(IDX_FLAG, 8'hff);
      wr(IDX_CTRL, {1'b0, n[3:0], 3'b100});
      chk_reg({31'h0, irq_o}, 32'h0, "irq cleared");
      np = 0;
      a = 0;
      do begin
        @(posedge clk_i);
        a++;
        if (pwm_timebase_o === 1'b1) np++;
      end while (irq_o !== 1'b1 && a < 600);
      chk_cnt(np, n + 1, "postscale");
    end
    // Sticky flag, write one to clear
    wr(IDX_CTRL, 8'h00);
    rd_chk(IDX_FLAG, 8'h02, "flag sticky");
    wr(IDX_FLAG, 8'h02);
    rd_chk(IDX_FLAG, 8'h00, "flag clear");
    // Masked: flag sets, interrupt stays low until unmasked
    wr(IDX_MASK, 8'h00);
    wr(IDX_COUNT, 8'h00);
    wr(IDX_CTRL, 8'h04);
    repeat (40) @(posedge clk_i);
    wr(IDX_CTRL, 8'h00);
    chk_reg({31'h0, irq_o}, 32'h0, "irq masked");
    rd_chk(IDX_FLAG, 8'h02, "flag masked");
    wr(IDX_MASK, 8'h02);
    rd_chk(IDX_MASK, 8'h02, "mask rw");
    chk_reg({31'h0, irq_o}, 32'h1, "irq unmasked");
    // A second reset in mid-run
    wr(IDX_COUNT, 8'h77);
    wr(IDX_PERIOD, 8'h40);
    wr(IDX_CTRL, 8'h04);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(IDX_COUNT, 8'h00, "count rereset");
    rd_chk(IDX_PERIOD, 8'hff, "period rereset");
    rd_chk(IDX_MASK, 8'h00, "mask rereset");
    rd_chk(IDX_CTRL, 8'h00, "ctrl rereset");
    chk_reg({31'h0, irq_o}, 32'h0, "irq rereset");
    report_and_stop();
  end
endmodule

`default_nettype wire
